// File: src/uic_ctrl.sv
`include "uic_params.svh"

//////////////////////////////////////////////////////////////////////////////
module uic_ctrl
  import uic_pkg::*;
#(
  parameter logic [3:0] SRC_SUPPORTED = 4'hf
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // clock sources and debug state
  input  wire logic        internal_osc,
  input  wire logic        low_speed_osc,
  input  wire logic        high_speed_osc,
  input  wire logic        external_clock_in,
  input  wire logic        debug_halt,
  // engine timing and reset
  output logic             operating_clock_tick,
  output logic             sample_tick,
  output logic             channel_reset,
  // transmit engine
  output logic      [7:0]  tx_data,
  output logic             tx_data_valid,
  input  wire logic        tx_take,
  input  wire logic        tx_stop_done,
  input  wire logic        tx_busy,
  input  wire logic        tx_line,
  input  wire logic        ir_tx_pulse,
  input  wire logic        carrier_wave,
  // receive engine
  input  wire logic        rx_push,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_frame_err,
  input  wire logic        rx_parity_err,
  input  wire logic        rx_busy,
  input  wire logic        ir_rx_line,
  output logic             rx_pin_level,
  output logic             rx_line,
  // settings to engines
  output logic             char_length,
  output logic             parity_enable,
  output logic             parity_type,
  output logic             stop_length,
  output logic      [7:0]  baud_count,
  output logic      [3:0]  fine_rate,
  output logic             input_pullup,
  // pins and interrupt
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    hit = (a[5:2] == o[5:2]);
  endfunction

  function automatic uic_word_t merge(input uic_word_t old,
                                     input logic [15:0] wd,
                                     input logic [1:0] be,
                                     input uic_word_t msk);
    uic_word_t m;
    m = old;
    if (be[0]) m[7:0] = wd[7:0];
    if (be[1]) m[15:8] = wd[15:8];
    merge = m & msk;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // declarations

  logic        ack_q;
  logic        wr_acc;
  logic        rd_acc;
  uic_word_t   clk_q;
  uic_word_t   mod_q;
  uic_word_t   br_q;
  logic        module_enable_q;
  logic [2:0]  srst_q;
  logic        srst_busy;
  uic_flags_t  flag_q;
  uic_flags_t  flag_d;
  uic_flags_t  flag_set;
  uic_flags_t  flag_clr;
  uic_flags_t  inte_q;
  uic_word_t   rd_word;
  logic        tx_full_q;
  logic [7:0]  tx_data_q;
  logic [1:0]  rx_cnt_q;
  logic [1:0]  rx_eff;
  logic [9:0]  rx_slot_q [2];
  logic        pop;
  logic        push_ok;
  logic        overrun;
  logic        head_err_fe;
  logic        head_err_pe;
  logic [3:0]  src_in;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic [3:0]  s3_q;
  logic [3:0]  src_f_q;
  logic        sel_prev_q;
  logic        sel_lvl;
  logic [2:0]  div_cnt_q;
  logic [2:0]  div_lim;
  logic        op_run;
  logic        op_tick_q;
  logic [3:0]  samp_cnt_q;
  logic [3:0]  samp_lim;
  logic        samp_tick_q;
  logic [2:0]  pin_q;
  logic        pin_f_q;
  logic        rx_pin_q;
  logic        rx_line_q;
  logic        tx_base;
  logic        out_q;
  logic [1:0]  new_src;

  //////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait cycle, then the access completes

  assign waitrequest = (read | write) & ~ack_q;
  assign wr_acc      = write & ack_q;
  assign rd_acc      = read & ack_q & ~write;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  always_comb begin
    rd_word = `UIC_REG_RST;
    if (hit(address, `UIC_OFS_CLK)) rd_word = clk_q;
    if (hit(address, `UIC_OFS_MOD)) rd_word = mod_q;
    if (hit(address, `UIC_OFS_BR))  rd_word = br_q;
    if (hit(address, `UIC_OFS_CTL)) begin
      rd_word[`UIC_SOFT_RESET_BIT] = srst_busy;
      rd_word[`UIC_MODULE_ENABLE]  = module_enable_q;
    end
    if (hit(address, `UIC_OFS_INTF)) begin
      rd_word[6:0]        = flag_q;
      rd_word[`UIC_F_TBSY] = tx_busy;
      rd_word[`UIC_F_RBSY] = rx_busy;
    end
    if (hit(address, `UIC_OFS_INTE)) rd_word[6:0] = inte_q;
    if (hit(address, `UIC_OFS_TXD))  rd_word[7:0] = tx_data_q;
    if (hit(address, `UIC_OFS_RXD) && rx_cnt_q != 2'h0) begin
      rd_word[7:0] = rx_slot_q[0][7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata <= {16'h0000, rd_word};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  assign new_src = writedata[`UIC_SRC_HI:`UIC_SRC_LO];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clk_q   <= `UIC_REG_RST;
      mod_q   <= `UIC_REG_RST;
      br_q    <= `UIC_REG_RST;
      module_enable_q <= 1'b0;
      inte_q  <= '0;
    end else if (wr_acc) begin
      if (hit(address, `UIC_OFS_CLK)) begin
        clk_q <= merge(clk_q, writedata[15:0], byteenable[1:0],
                       `UIC_CLK_MASK);
        if (!SRC_SUPPORTED[new_src] || !byteenable[0]) begin
          clk_q[`UIC_SRC_HI:`UIC_SRC_LO] <=
            clk_q[`UIC_SRC_HI:`UIC_SRC_LO];
        end
      end
      if (hit(address, `UIC_OFS_MOD)) begin
        mod_q <= merge(mod_q, writedata[15:0], byteenable[1:0],
                       `UIC_MOD_MASK);
      end
      if (hit(address, `UIC_OFS_BR)) begin
        br_q <= merge(br_q, writedata[15:0], byteenable[1:0],
                      `UIC_BR_MASK);
      end
      if (hit(address, `UIC_OFS_CTL) && byteenable[0]) begin
        module_enable_q <= writedata[`UIC_MODULE_ENABLE];
      end
      if (hit(address, `UIC_OFS_INTE) && byteenable[0]) begin
        inte_q <= writedata[6:0] & `UIC_INTE_MASK;
      end
    end
  end

  assign char_length   = mod_q[`UIC_CHAR_LENGTH];
  assign parity_enable = mod_q[`UIC_PARITY_ENABLE];
  assign parity_type   = mod_q[`UIC_PARITY_TYPE];
  assign stop_length   = mod_q[`UIC_STOP_LENGTH];
  assign input_pullup  = mod_q[`UIC_INPUT_PULLUP];
  assign baud_count    = br_q[`UIC_BRT_HI:`UIC_BRT_LO];
  assign fine_rate     = br_q[`UIC_FMD_HI:`UIC_FMD_LO];

  //////////////////////////////////////////////////////////////////////////
  // software reset: busy for a fixed count, then self-clears

  assign srst_busy     = (srst_q != 3'h0);
  assign channel_reset = srst_busy;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      srst_q <= 3'h0;
    end else if (wr_acc && hit(address, `UIC_OFS_CTL) && byteenable[0]
                 && writedata[`UIC_SOFT_RESET_BIT]) begin
      srst_q <= `UIC_SRST_LEN;
    end else if (srst_busy) begin
      srst_q <= srst_q - 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit buffer

  assign tx_data       = tx_data_q;
  assign tx_data_valid = tx_full_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else if (srst_busy) begin
      tx_full_q <= 1'b0;
    end else if (wr_acc && hit(address, `UIC_OFS_TXD) && byteenable[0]) begin
      tx_full_q <= 1'b1;
      tx_data_q <= writedata[7:0];
    end else if (tx_take) begin
      tx_full_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // two-entry receive buffer, slot 0 is the oldest byte

  assign pop     = rd_acc && hit(address, `UIC_OFS_RXD) && rx_cnt_q != 2'h0;
  assign rx_eff  = rx_cnt_q - {1'b0, pop};
  assign push_ok = rx_push && rx_eff != 2'h2;
  assign overrun = rx_push && rx_eff == 2'h2;

  assign head_err_fe = rx_slot_q[0][9];
  assign head_err_pe = rx_slot_q[0][8];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_q     <= 2'h0;
      rx_slot_q[0] <= '0;
      rx_slot_q[1] <= '0;
    end else if (srst_busy) begin
      rx_cnt_q <= 2'h0;
    end else begin
      if (pop) begin
        rx_slot_q[0] <= rx_slot_q[1];
      end
      if (push_ok) begin
        rx_slot_q[rx_eff[0]] <= {rx_frame_err, rx_parity_err, rx_data};
      end
      rx_cnt_q <= rx_eff + {1'b0, push_ok};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt flags: set wins over clear, soft reset wins over both

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    if (wr_acc && hit(address, `UIC_OFS_INTF) && byteenable[0]) begin
      flag_clr = writedata[6:0] & `UIC_INTF_W1C;
    end
    flag_set[`UIC_F_TBE] = tx_take & tx_full_q;
    if (wr_acc && hit(address, `UIC_OFS_TXD) && byteenable[0]) begin
      flag_clr[`UIC_F_TBE] = 1'b1;
    end
    flag_set[`UIC_F_TEND] = tx_stop_done & flag_q[`UIC_F_TBE]
                            & ~tx_full_q;
    flag_set[`UIC_F_OE]   = overrun;
    flag_set[`UIC_F_RB1]  = push_ok & (rx_eff == 2'h0);
    flag_set[`UIC_F_RB2]  = push_ok & (rx_eff == 2'h1);
    if (pop) begin
      flag_clr[`UIC_F_RB2] = 1'b1;
      flag_clr[`UIC_F_RB1] = (rx_cnt_q == 2'h1);
      flag_clr[`UIC_F_FE]  = flag_clr[`UIC_F_FE] | head_err_fe;
      flag_clr[`UIC_F_PE]  = flag_clr[`UIC_F_PE] | head_err_pe;
      if (rx_cnt_q == 2'h2) begin
        flag_set[`UIC_F_FE] = rx_slot_q[1][9];
        flag_set[`UIC_F_PE] = rx_slot_q[1][8];
      end
    end
    if (push_ok && rx_eff == 2'h0) begin
      flag_set[`UIC_F_FE] = rx_frame_err;
      flag_set[`UIC_F_PE] = rx_parity_err;
    end
    flag_d = (flag_q & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= `UIC_INTF_RST;
    end else if (srst_busy) begin
      flag_q <= `UIC_INTF_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign irq = |(flag_q & inte_q);

  //////////////////////////////////////////////////////////////////////////
  // clock sources: three-stage filter, selection, divider, gating

  assign src_in = {external_clock_in, high_speed_osc,
                   low_speed_osc, internal_osc};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_src
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi]    <= 1'b0;
          s2_q[gi]    <= 1'b0;
          s3_q[gi]    <= 1'b0;
          src_f_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= src_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) src_f_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  assign sel_lvl = src_f_q[clk_q[`UIC_SRC_HI:`UIC_SRC_LO]];
  assign op_run  = module_enable_q & (~debug_halt | clk_q[`UIC_DEBUG_CLOCK_RUN]);

  always_comb begin
    unique case (uic_src_e'(clk_q[`UIC_SRC_HI:`UIC_SRC_LO]))
      UIC_SRC_INTERNAL, UIC_SRC_HIGH_SPEED: begin
        div_lim = 3'((4'h1 << clk_q[`UIC_DIV_HI:`UIC_DIV_LO]) - 4'h1);
      end
      UIC_SRC_LOW_SPEED, UIC_SRC_EXTERNAL: begin
        div_lim = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b0;
      div_cnt_q  <= 3'h0;
      op_tick_q  <= 1'b0;
    end else begin
      sel_prev_q <= sel_lvl;
      op_tick_q  <= 1'b0;
      if (!op_run) begin
        div_cnt_q <= 3'h0;
      end else if (sel_lvl && !sel_prev_q) begin
        if (div_cnt_q >= div_lim) begin
          div_cnt_q <= 3'h0;
          op_tick_q <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 3'h1;
        end
      end
    end
  end

  assign operating_clock_tick = op_tick_q;

  assign samp_lim = mod_q[`UIC_SAMPLING_DIVIDER] ? `UIC_SDIV_FAST
                                      : `UIC_SDIV_SLOW;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_q  <= 4'h0;
      samp_tick_q <= 1'b0;
    end else begin
      samp_tick_q <= 1'b0;
      if (srst_busy) begin
        samp_cnt_q <= 4'h0;
      end else if (op_tick_q) begin
        if (samp_cnt_q >= samp_lim) begin
          samp_cnt_q  <= 4'h0;
          samp_tick_q <= 1'b1;
        end else begin
          samp_cnt_q <= samp_cnt_q + 4'h1;
        end
      end
    end
  end

  assign sample_tick = samp_tick_q;

  //////////////////////////////////////////////////////////////////////////
  // serial line paths

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q   <= 3'h7;
      pin_f_q <= 1'b1;
    end else begin
      pin_q <= {pin_q[1:0], serial_in_pin};
      if (pin_q[1] == pin_q[2]) pin_f_q <= pin_q[2];
    end
  end

  assign tx_base = mod_q[`UIC_INFRARED_MODE] ? ir_tx_pulse : tx_line;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_pin_q  <= 1'b1;
      rx_line_q <= 1'b1;
      out_q     <= 1'b1;
    end else begin
      rx_pin_q  <= pin_f_q ^ mod_q[`UIC_RX_INVERT];
      rx_line_q <= mod_q[`UIC_INFRARED_MODE] ? ir_rx_line
                                    : (pin_f_q ^ mod_q[`UIC_RX_INVERT]);
      if (mod_q[`UIC_CARRIER_ENABLE] &&
          tx_base == mod_q[`UIC_CARRIER_PERIOD_SEL]) begin
        out_q <= carrier_wave ^ mod_q[`UIC_TX_INVERT];
      end else begin
        out_q <= tx_base ^ mod_q[`UIC_TX_INVERT];
      end
    end
  end

  assign rx_pin_level   = rx_pin_q;
  assign rx_line        = rx_line_q;
  assign serial_out_pin = out_q & ~mod_q[`UIC_OUTPUT_DRIVE_MODE];
  assign serial_out_oe  = mod_q[`UIC_OUTPUT_DRIVE_MODE] ? ~out_q : 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  property p_tend;
    @(posedge clock) disable iff (!rst_n)
    tx_stop_done && flag_q[`UIC_F_TBE] && !tx_full_q && !srst_busy
      |=> flag_q[`UIC_F_TEND];
  endproperty
  a_tend: assert property (p_tend)
    else $error("end flag not set after stop");

  property p_fe_clr;
    @(posedge clock) disable iff (!rst_n)
    pop && head_err_fe && !srst_busy && !rx_slot_q[1][9] && !rx_push
      |=> !flag_q[`UIC_F_FE];
  endproperty
  a_fe_clr: assert property (p_fe_clr)
    else $error("framing flag kept after errored read");

  property p_oe_hold;
    @(posedge clock) disable iff (!rst_n)
    flag_q[`UIC_F_OE] && pop && !srst_busy && !flag_clr[`UIC_F_OE]
      |=> flag_q[`UIC_F_OE];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("overrun flag cleared by read");

  property p_rb2;
    @(posedge clock) disable iff (!rst_n)
    rx_push && rx_cnt_q == 2'h1 && !pop && !srst_busy
      |=> flag_q[`UIC_F_RB2] && rx_cnt_q == 2'h2;
  endproperty
  a_rb2: assert property (p_rb2)
    else $error("two-full flag missed");

  property p_rb1_clr;
    @(posedge clock) disable iff (!rst_n)
    pop && rx_cnt_q == 2'h1 && !rx_push && !srst_busy
      |=> !flag_q[`UIC_F_RB1] && rx_cnt_q == 2'h0;
  endproperty
  a_rb1_clr: assert property (p_rb1_clr)
    else $error("one-full flag kept after emptying");

  property p_tbe;
    @(posedge clock) disable iff (!rst_n)
    tx_take && tx_full_q && !srst_busy
      |=> flag_q[`UIC_F_TBE] && !tx_data_valid;
  endproperty
  a_tbe: assert property (p_tbe)
    else $error("tx empty flag missed on transfer");

  property p_irq;
    @(posedge clock) disable iff (!rst_n)
    $rose(irq) |-> $changed(flag_q) || $changed(inte_q);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq raised without enabled flag");

  property p_srst;
    @(posedge clock) disable iff (!rst_n)
    wr_acc && hit(address, `UIC_OFS_CTL) && byteenable[0]
      && writedata[`UIC_SOFT_RESET_BIT] && !srst_busy
      |=> srst_busy[*4] ##1 (!srst_busy && flag_q == `UIC_INTF_RST);
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset length or flag clear wrong");

  property p_gate;
    @(posedge clock) disable iff (!rst_n)
    !module_enable_q || (debug_halt && !clk_q[`UIC_DEBUG_CLOCK_RUN])
      |=> !operating_clock_tick;
  endproperty
  a_gate: assert property (p_gate)
    else $error("operating tick while gated");

  c_tend: cover property (@(posedge clock) disable iff (!rst_n)
    $rose(flag_q[`UIC_F_TEND]));
  c_overrun: cover property (@(posedge clock) disable iff (!rst_n)
    overrun);
  c_two_full: cover property (@(posedge clock) disable iff (!rst_n)
    rx_cnt_q == 2'h2 ##1 pop);

endmodule

// File: src/uic_params.svh
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH

// register byte offsets
`define UIC_OFS_CLK    6'h00
`define UIC_OFS_MOD    6'h04
`define UIC_OFS_BR     6'h08
`define UIC_OFS_CTL    6'h0c
`define UIC_OFS_INTF   6'h10
`define UIC_OFS_INTE   6'h14
`define UIC_OFS_TXD    6'h18
`define UIC_OFS_RXD    6'h1c

// writable bits of each register
`define UIC_CLK_MASK   16'h0133
`define UIC_MOD_MASK   16'h1f7f
`define UIC_BR_MASK    16'h0fff
`define UIC_INTE_MASK  7'h7f
`define UIC_INTF_W1C   7'h78

// clock_select fields
`define UIC_DEBUG_CLOCK_RUN      8
`define UIC_DIV_HI     5
`define UIC_DIV_LO     4
`define UIC_SRC_HI     1
`define UIC_SRC_LO     0

// line_mode fields
`define UIC_CARRIER_PERIOD_SEL      12
`define UIC_CARRIER_ENABLE      11
`define UIC_SAMPLING_DIVIDER      10
`define UIC_RX_INVERT      9
`define UIC_TX_INVERT      8
`define UIC_INPUT_PULLUP       6
`define UIC_OUTPUT_DRIVE_MODE      5
`define UIC_INFRARED_MODE       4
`define UIC_CHAR_LENGTH       3
`define UIC_PARITY_ENABLE       2
`define UIC_PARITY_TYPE       1
`define UIC_STOP_LENGTH       0

// rate_setting fields
`define UIC_FMD_HI     11
`define UIC_FMD_LO     8
`define UIC_BRT_HI     7
`define UIC_BRT_LO     0

// channel_control fields
`define UIC_SOFT_RESET_BIT     1
`define UIC_MODULE_ENABLE      0

// irq_flag_reg bit positions
`define UIC_F_TBE      0
`define UIC_F_RB1      1
`define UIC_F_RB2      2
`define UIC_F_OE       3
`define UIC_F_PE       4
`define UIC_F_FE       5
`define UIC_F_TEND     6
`define UIC_F_TBSY     8
`define UIC_F_RBSY     9

// reset values and counts
`define UIC_REG_RST    16'h0000
`define UIC_INTF_RST   7'h01
`define UIC_SRST_LEN   3'h4
`define UIC_SDIV_FAST  4'h3
`define UIC_SDIV_SLOW  4'hf

`endif

// File: src/uic_pkg.sv
package uic_pkg;

  typedef logic [15:0] uic_word_t;
  typedef logic [6:0]  uic_flags_t;

  // operating clock sources
  typedef enum logic [1:0] {
    UIC_SRC_INTERNAL,
    UIC_SRC_LOW_SPEED,
    UIC_SRC_HIGH_SPEED,
    UIC_SRC_EXTERNAL
  } uic_src_e;

endpackage

// File: verification/uart_irq_and_control_regs_test.sv
module uart_irq_and_control_regs_test;
  import uic_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_n = 0, read = 0, write = 0, debug_halt = 0;
  logic [5:0] address = 0;
  logic [31:0] writedata = 0, readdata;
  logic waitrequest, ios = 0, los = 0, hos = 0, exc = 0, otk, stk, crst;
  logic [7:0] tx_data, rx_data = 0, baud_count, rnd = 8'h5e;
  logic tdv, take, stop, tbsy, tl = 0, irp = 0, cw = 0, rx_push = 0;
  logic fe = 0, pe = 0, irl = 0, sin = 1, cl, pen, pty, stl, irq;
  logic sop, soe, line_on = 0, exp_out = 1;
  logic [1:0] osc_cnt = 0;
  logic [31:0] expq[$];
  int error_cnt = 0, num_checks = 0, i;
  uic_ctrl DUT (.clock(clock), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(4'h3),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .internal_osc(ios), .low_speed_osc(los),
    .high_speed_osc(hos), .external_clock_in(exc),
    .debug_halt(debug_halt), .operating_clock_tick(otk),
    .sample_tick(stk), .channel_reset(crst), .tx_data(tx_data),
    .tx_data_valid(tdv), .tx_take(take), .tx_stop_done(stop),
    .tx_busy(tbsy), .tx_line(tl), .ir_tx_pulse(irp), .carrier_wave(cw),
    .rx_push(rx_push), .rx_data(rx_data), .rx_frame_err(fe),
    .rx_parity_err(pe), .rx_busy(1'b0), .ir_rx_line(irl),
    .rx_pin_level(), .rx_line(), .char_length(cl), .parity_enable(pen),
    .parity_type(pty), .stop_length(stl), .baud_count(baud_count),
    .fine_rate(), .input_pullup(), .serial_in_pin(sin),
    .serial_out_pin(sop), .serial_out_oe(soe), .irq(irq));
  uic_engine_model eng (.clock(clock), .rst_n(rst_n),
    .tx_data_valid(tdv), .tx_take(take), .tx_stop_done(stop),
    .tx_busy(tbsy));
  initial forever #25 clock = ~clock;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always @(posedge clock) begin
    rnd <= lfsr(rnd);
    {los, hos, exc, tl, irp, cw, irl, sin} <= rnd;
    osc_cnt <= osc_cnt + 2'h1;
    ios <= osc_cnt[1];
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // line output against the written mode: carrier high, inverted, open drain
  always @(posedge clock) begin
    if (line_on) begin
      check({sop, soe}, {1'b0, ~exp_out});
    end
    exp_out <= tl ? ~cw : 1'b1;
  end
  task automatic conclude;
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one avalon access, expectation queued for reads
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d, input logic [15:0] m = 16'hffff);
    logic done;
    done = 0;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {16'h0, d};
    if (!w) expq.push_back({m, d});
    for (i = 0; i < 20 && !done; i++) @(posedge clock) done = !waitrequest;
    read <= 0;
    write <= 0;
    if (!done) begin error_cnt++; conclude(); end
  endtask
  task automatic wait_on(ref logic s, input logic v);
    for (i = 0; i < 200 && s !== v; i++) @(posedge clock);
    if (s !== v) begin error_cnt++; conclude(); end
  endtask
  task automatic rxp(input logic [7:0] d, input logic f);
    @(posedge clock);
    rx_push <= 1;
    rx_data <= d;
    fe <= f;
    pe <= f;
    @(posedge clock);
    rx_push <= 0;
    fe <= 0;
    pe <= 0;
  endtask
  // compares read data with the oldest expectation
  always @(posedge clock) begin
    logic [31:0] e;
    if (read && !waitrequest && expq.size() > 0) begin
      e = expq.pop_front();
      check(readdata & {16'h0, e[31:16]}, {16'h0, e[15:0]});
    end
  end
  initial begin
    logic [7:0] b;
    repeat (6) @(posedge clock);
    rst_n <= 1;
    bus(0, 6'h10, 16'h0001);
    bus(1, 6'h00, 16'hffff);
    bus(0, 6'h00, 16'h0133);
    bus(1, 6'h04, 16'hffef);
    bus(0, 6'h04, 16'h1f6f);
    line_on <= 1;
    check({cl, pen, pty, stl}, 4'hf);
    b = rnd;
    bus(1, 6'h08, {8'hf3, b});
    bus(0, 6'h08, {8'h03, b});
    check(baud_count, b);
    bus(0, 6'h20, 16'h0000);
    bus(1, 6'h00, 16'h0000);
    rxp(8'ha5, 0);
    rxp(8'h3c, 1);
    bus(0, 6'h10, 16'h0007);
    rxp(8'h77, 0);
    bus(0, 6'h10, 16'h000f);
    bus(0, 6'h1c, 16'h00a5);
    bus(0, 6'h10, 16'h003b);
    bus(0, 6'h1c, 16'h003c);
    bus(0, 6'h10, 16'h0009);
    bus(1, 6'h10, 16'h0008);
    bus(0, 6'h10, 16'h0001);
    bus(1, 6'h14, 16'h0040);
    check(irq, 1'b0);
    bus(1, 6'h18, 16'h005a);
    wait_on(irq, 1'b1);
    bus(0, 6'h10, 16'h0041);
    bus(1, 6'h10, 16'h0040);
    bus(0, 6'h10, 16'h0001);
    rxp(8'h11, 0);
    bus(1, 6'h0c, 16'h0002);
    bus(0, 6'h0c, 16'h0002);
    wait_on(crst, 1'b0);
    bus(0, 6'h0c, 16'h0000);
    bus(0, 6'h10, 16'h0001);
    bus(1, 6'h0c, 16'h0001);
    wait_on(otk, 1'b1);
    wait_on(stk, 1'b1);
    debug_halt <= 1;
    repeat (3) @(posedge clock);
    b = 0;
    repeat (40) @(posedge clock) if (otk) b++;
    check(b, 8'h00);
    repeat (2) @(posedge clock);
    conclude();
  end
endmodule

// File: verification/uic_engine_model.sv
module uic_engine_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // transmit engine handshake
  input  wire logic tx_data_valid,
  output logic      tx_take,
  output logic      tx_stop_done,
  output logic      tx_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // takes a byte, sends the frame, ends it some cycles later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q        <= 4'h0;
      tx_take      <= 1'b0;
      tx_stop_done <= 1'b0;
      tx_busy      <= 1'b0;
    end else begin
      tx_take      <= tx_data_valid && !tx_busy && !tx_take;
      tx_stop_done <= cnt_q == 4'h1;
      if (tx_take) begin
        tx_busy <= 1'b1;
        cnt_q   <= 4'h9;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
      if (cnt_q == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end
  end
endmodule
